//--- hdl/srt_top.sv
// Purpose: Supervisory reset timer that forces a controller reset on overflow
// Assumes: Control requests are one-cycle pulses synchronous to clk
// Notes:   Overflow reset reinitialises this block too; the sticky cause
//          flag survives it and is cleared only by rst or cause_clr
`default_nettype none

module srt_top
  import srt_pkg::*;
#(
  parameter int MIN_LOG2  = SRT_MIN_LOG2_DEF,
  parameter int STEP_LOG2 = SRT_STEP_LOG2_DEF
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 lfo_in,
  input  wire logic                 restart_req,
  input  wire logic                 disable_req,
  input  wire logic                 enable_req,
  input  wire logic                 lock_req,
  input  wire logic                 sel_wr_req,
  input  wire logic [SRT_SEL_W-1:0] sel_wr_val,
  input  wire logic                 cause_clr,
  output logic                      wdt_rst_q,
  output logic                      running_q,
  output logic                      locked_q,
  output logic [SRT_SEL_W-1:0]      sel_q,
  output logic                      cause_q,
  output logic                      ext_rst_pin_oe_q
);

  localparam int CNT_W = MIN_LOG2 + STEP_LOG2 * int'(SRT_SEL_MAX) + 1;

  // Refuse shapes the counter cannot hold
  if (MIN_LOG2 < 1 || STEP_LOG2 < 1 || CNT_W > 32) begin : g_chk
    $error("srt_top: MIN_LOG2/STEP_LOG2 out of range");
  end

  srt_tick_if tick_if ();

  srt_lfo_tick u_tick (
    .clk     (clk),
    .rst     (rst),
    .lfo_in  (lfo_in),
    .tick_if (tick_if.src)
  );

  srt_state_type      state_q;
  srt_state_type      state_d;
  logic [CNT_W-1:0]   cnt_q;
  logic [CNT_W-1:0]   cnt_d;
  logic [2:0]         fire_q;
  logic [2:0]         fire_d;
  logic [SRT_SEL_W-1:0] sel_d;
  logic               locked_d;
  logic               wdt_rst_d;
  logic               running_d;
  logic               cause_d;
  logic [CNT_W-1:0]   lim_m1;
  logic               tick;
  logic               ovf_hit;

  assign tick = tick_if.tick;

  // Last count before overflow for the selected interval
  assign lim_m1  = (CNT_W'(1) << (MIN_LOG2 + STEP_LOG2 * int'(sel_q))) - CNT_W'(1);
  assign ovf_hit = (state_q == SRT_RUN) && tick && !restart_req
                   && (cnt_q == lim_m1);

  // Timer state, count, configuration and lock
  always_comb begin
    state_d   = state_q;
    cnt_d     = cnt_q;
    fire_d    = fire_q;
    sel_d     = sel_q;
    locked_d  = locked_q;
    wdt_rst_d = 1'b0;
    unique case (state_q)
      SRT_RUN: begin
        if (restart_req) begin
          cnt_d = '0;
        end else if (tick) begin
          cnt_d = cnt_q + CNT_W'(1);
        end
        // Configuration only while unlocked; a lock freezes it
        if (!locked_q) begin
          if (sel_wr_req) begin
            sel_d = sel_wr_val;
            cnt_d = '0;
          end
          if (disable_req && !lock_req) begin
            state_d = SRT_OFF;
            cnt_d   = '0;
          end
        end
        if (lock_req) begin
          locked_d = 1'b1;
        end
        // Overflow wins over any request in the same cycle except restart, which blocks it
        if (ovf_hit) begin
          state_d   = SRT_FIRE;
          fire_d    = 3'h0;
          wdt_rst_d = 1'b1;
        end
      end
      SRT_OFF: begin
        if (sel_wr_req) begin
          sel_d = sel_wr_val;
        end
        // Locking a stopped timer also starts it, so it cannot stay off
        if (enable_req || lock_req) begin
          state_d  = SRT_RUN;
          cnt_d    = '0;
          locked_d = lock_req;
        end
      end
      SRT_FIRE: begin
        wdt_rst_d = 1'b1;
        fire_d    = fire_q + 3'h1;
        if (fire_q == SRT_FIRE_LAST) begin
          // Leave as after any reset: running, longest interval, unlocked
          state_d   = SRT_RUN;
          sel_d     = SRT_SEL_MAX;
          locked_d  = 1'b0;
          cnt_d     = '0;
          fire_d    = 3'h0;
          wdt_rst_d = 1'b0;
        end
      end
      default: begin
        state_d = SRT_FIRE;
        fire_d  = 3'h0;
      end
    endcase
    running_d = (state_d == SRT_RUN);
    // Sticky cause flag: a new overflow beats a clear in the same cycle
    cause_d = ovf_hit ? 1'b1 : (cause_clr ? 1'b0 : cause_q);
  end

  // Registers; reset lands in the running state at the longest interval
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q          <= SRT_RUN;
      cnt_q            <= '0;
      fire_q           <= 3'h0;
      sel_q            <= SRT_SEL_MAX;
      locked_q         <= 1'b0;
      wdt_rst_q        <= 1'b0;
      running_q        <= 1'b1;
      cause_q          <= 1'b0;
      ext_rst_pin_oe_q <= 1'b0;
    end else begin
      state_q          <= state_d;
      cnt_q            <= cnt_d;
      fire_q           <= fire_d;
      sel_q            <= sel_d;
      locked_q         <= locked_d;
      wdt_rst_q        <= wdt_rst_d;
      running_q        <= running_d;
      cause_q          <= cause_d;
      ext_rst_pin_oe_q <= 1'b0;
    end
  end

  // Checks on the timer behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  overflow_fire_a: assert property (
    ovf_hit |=> wdt_rst_q [*4] ##1 (!wdt_rst_q && running_q))
    else $error("overflow did not give a four-cycle reset pulse");

  reset_default_a: assert property (
    $fell(wdt_rst_q) |-> running_q && sel_q == SRT_SEL_MAX && !locked_q
                         && cnt_q == '0)
    else $error("timer not at defaults after overflow reset");

  disable_ok_a: assert property (
    (state_q == SRT_RUN && !locked_q && disable_req && !lock_req && !ovf_hit)
      |=> !running_q && !wdt_rst_q)
    else $error("unlocked disable was not honoured");

  lock_hold_a: assert property (
    (locked_q && state_q == SRT_RUN && !ovf_hit)
      |=> running_q && locked_q && $stable(sel_q))
    else $error("locked timer was stopped or reconfigured");

  pin_quiet_a: assert property (
    wdt_rst_q |-> !ext_rst_pin_oe_q)
    else $error("external reset pin driven during overflow reset");

  tick_only_a: assert property (
    (state_q == SRT_RUN && !tick && !restart_req && !sel_wr_req && !disable_req)
      |=> $stable(cnt_q))
    else $error("count moved without an oscillator tick");

  restart_clear_a: assert property (
    (state_q == SRT_RUN && restart_req) |=> cnt_q == '0 && !wdt_rst_q)
    else $error("restart did not clear the count");

  cause_set_a: assert property (
    ovf_hit |=> cause_q)
    else $error("overflow did not set the cause flag");

  off_quiet_a: assert property (
    (state_q == SRT_OFF && !enable_req && !lock_req) |=> !running_q && !wdt_rst_q)
    else $error("stopped timer started or fired by itself");

  sel_write_a: assert property (
    (state_q == SRT_RUN && !locked_q && sel_wr_req && !ovf_hit)
      |=> sel_q == $past(sel_wr_val))
    else $error("unlocked interval write was not taken");

  // Main scenarios the bench is expected to reach
  fire_c:     cover property (ovf_hit ##1 wdt_rst_q);
  lock_c:     cover property (locked_q && disable_req);
  disable_c:  cover property ($fell(running_q) && !wdt_rst_q);
  restart_c:  cover property (state_q == SRT_RUN && restart_req);
  lock_off_c: cover property (state_q == SRT_OFF && lock_req);

endmodule

`default_nettype wire

//--- hdl/srt_pkg.sv
// Purpose: Shared constants and types for the supervisory reset timer
// Assumes: System clock clk at 200 MHz; low-frequency oscillator near 80 kHz
// Notes:   Timeout lengths are counted in oscillator ticks, not clk cycles
//
// Functional notes
// - Overflow forces the whole controller into reset.
// - After reset: enabled, counting, longest interval.
// - Software may disable timer unless locked.
// - Lock blocks disable/reconfigure until next reset.
// - Overflow reset never drives the external pin.
// - Timer counts low-frequency oscillator, not system clock.
`default_nettype none

package srt_pkg;

  // Clock figures
  localparam int SRT_CLK_PERIOD_PS = 5000;
  localparam int SRT_LFO_FREQ_HZ   = 80000;
  localparam int SRT_CLK_FREQ_HZ   = 200000000;
  // Nominal clk cycles per oscillator period, for sizing tests
  localparam int SRT_LFO_PERIOD_CYC = SRT_CLK_FREQ_HZ / SRT_LFO_FREQ_HZ;

  // Width of the reset request pulse, least time rounded up to cycles
  localparam int SRT_FIRE_TIME_NS = 20;
  localparam int SRT_FIRE_CYC     =
    (SRT_FIRE_TIME_NS * 1000 + SRT_CLK_PERIOD_PS - 1) / SRT_CLK_PERIOD_PS;
  localparam logic [2:0] SRT_FIRE_LAST = 3'(SRT_FIRE_CYC - 1);

  // Interval select: eight settings, the highest is the longest
  localparam int         SRT_SEL_W   = 3;
  localparam logic [2:0] SRT_SEL_MAX = 3'h7;

  // Default interval shape: ticks = 2**(MIN_LOG2 + STEP_LOG2*sel)
  localparam int SRT_MIN_LOG2_DEF  = 6;
  localparam int SRT_STEP_LOG2_DEF = 2;

  // Synchroniser depth on the oscillator input
  localparam int SRT_SYNC_STAGES = 2;

  typedef enum logic [2:0] {
    SRT_RUN  = 3'b001,
    SRT_OFF  = 3'b010,
    SRT_FIRE = 3'b100
  } srt_state_type;

endpackage

`default_nettype wire

//--- hdl/srt_tick_if.sv
// Purpose: Carries the oscillator tick from the edge detector to the timer
// Assumes: Both ends run on clk
// Notes:   tick is a one-cycle pulse per oscillator rising edge
`default_nettype none

interface srt_tick_if;
  logic tick;

  modport src (output tick);
  modport snk (input  tick);
endinterface

`default_nettype wire

//--- hdl/srt_lfo_tick.sv
// Purpose: Synchronise the oscillator and emit one tick per rising edge
// Assumes: Oscillator far slower than clk, so no edge is missed
// Notes:   First sync stage feeds only the second stage
`default_nettype none

module srt_lfo_tick
  import srt_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   rst,
  input  wire logic   lfo_in,
  srt_tick_if.src     tick_if
);

  logic [SRT_SYNC_STAGES-1:0] sync_q;
  logic [SRT_SYNC_STAGES-1:0] sync_d;
  logic                       prev_q;
  logic                       prev_d;
  logic                       tick_q;
  logic                       tick_d;

  // Shift chain and edge detect on the last stage only
  always_comb begin
    sync_d = {sync_q[SRT_SYNC_STAGES-2:0], lfo_in};
    prev_d = sync_q[SRT_SYNC_STAGES-1];
    tick_d = sync_q[SRT_SYNC_STAGES-1] & ~prev_q;
  end

  // Registers; tick leaves from a flop to keep the counter glitch free
  always_ff @(posedge clk) begin
    if (rst) begin
      sync_q <= '0;
      prev_q <= 1'b0;
      tick_q <= 1'b0;
    end else begin
      sync_q <= sync_d;
      prev_q <= prev_d;
      tick_q <= tick_d;
    end
  end

  assign tick_if.tick = tick_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  tick_single_a: assert property (tick_q |=> !tick_q)
    else $error("oscillator tick lasted more than one cycle");

endmodule

`default_nettype wire

//--- test/srt_tb.sv
// Purpose: Self-checking bench for the supervisory reset timer top
// Assumes: Short interval law (MIN_LOG2=1, STEP_LOG2=1); oscillator sped up
// Notes:   Oscillator is a bench pulse train so tick counts are exact
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import srt_pkg::*;

  logic                 clk;
  logic                 rst;
  logic                 lfo_in;
  logic [5:0]           rq;
  logic [SRT_SEL_W-1:0] sel_wr_val;
  logic                 wdt_rst_q;
  logic                 running_q;
  logic                 locked_q;
  logic [SRT_SEL_W-1:0] sel_q;
  logic                 cause_q;
  logic                 ext_rst_pin_oe_q;
  int                   hi_cnt;
  int                   oe_bad;
  int                   failures;
  int                   num_checks;

  // Request bits: 0 restart, 1 disable, 2 enable, 3 lock, 4 select write, 5 cause clear
  srt_top #(.MIN_LOG2(1), .STEP_LOG2(1)) dut (
    .clk(clk), .rst(rst), .lfo_in(lfo_in), .restart_req(rq[0]), .disable_req(rq[1]),
    .enable_req(rq[2]), .lock_req(rq[3]), .sel_wr_req(rq[4]), .sel_wr_val(sel_wr_val),
    .cause_clr(rq[5]), .wdt_rst_q(wdt_rst_q), .running_q(running_q), .locked_q(locked_q),
    .sel_q(sel_q), .cause_q(cause_q), .ext_rst_pin_oe_q(ext_rst_pin_oe_q));

  // Clock at 200 MHz
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Count reset-request cycles and pin drive; counters only grow, tests use snapshots
  always @(posedge clk) begin
    if (wdt_rst_q === 1'b1) begin
      hi_cnt <= hi_cnt + 1;
    end
    if (rst === 1'b0 && ext_rst_pin_oe_q !== 1'b0) begin
      oe_bad <= oe_bad + 1;
    end
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic pulse(input logic [5:0] m);
    @(negedge clk) rq = m;
    @(negedge clk) rq = 6'h00;
  endtask

  task automatic set_sel(input logic [2:0] v);
    sel_wr_val = v;
    pulse(6'h10);
  endtask

  // Each oscillator period is 20 clk cycles, long enough for the tick path to land
  task automatic lfo(input int n);
    repeat (n) begin
      repeat (10) @(negedge clk) lfo_in = 1'b1;
      repeat (10) @(negedge clk) lfo_in = 1'b0;
    end
  endtask

  task automatic do_reset();
    rst = 1'b1;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
  endtask

  task automatic test_reset();
    do_reset();
    check("running", running_q, 1);
    check("sel", sel_q, SRT_SEL_MAX);
    check("locked", locked_q, 0);
    check("cause", cause_q, 0);
    check("wdt_rst", wdt_rst_q, 0);
    $display("test_reset done");
  endtask

  task automatic test_overflow();
    int base;
    set_sel(3'h0);
    check("sel", sel_q, 0);
    base = hi_cnt;
    lfo(1);
    check("fired", 8'(hi_cnt - base), 0);
    lfo(1);
    check("fired", 8'(hi_cnt != base), 1);
    check("pulse_len", 8'(hi_cnt - base), SRT_FIRE_CYC);
    check("cause", cause_q, 1);
    check("sel", sel_q, SRT_SEL_MAX);
    check("running", running_q, 1);
    pulse(6'h20);
    check("cause", cause_q, 0);
    $display("test_overflow done");
  endtask

  task automatic test_restart();
    int base;
    set_sel(3'h1);
    check("sel", sel_q, 1);
    base = hi_cnt;
    lfo(3);
    pulse(6'h01);
    lfo(3);
    check("fired", 8'(hi_cnt - base), 0);
    lfo(1);
    check("fired", 8'(hi_cnt != base), 1);
    $display("test_restart done");
  endtask

  task automatic test_disable();
    int base;
    set_sel(3'h0);
    base = hi_cnt;
    repeat (200) @(negedge clk);
    check("fired", 8'(hi_cnt - base), 0);
    pulse(6'h02);
    check("running", running_q, 0);
    lfo(4);
    check("fired", 8'(hi_cnt - base), 0);
    // Interval write while stopped is taken and used once restarted
    set_sel(3'h1);
    check("sel", sel_q, 1);
    pulse(6'h04);
    check("running", running_q, 1);
    lfo(3);
    check("fired", 8'(hi_cnt - base), 0);
    lfo(1);
    check("fired", 8'(hi_cnt - base), SRT_FIRE_CYC);
    $display("test_disable done");
  endtask

  task automatic test_lock();
    pulse(6'h0A);
    check("locked", locked_q, 1);
    check("running", running_q, 1);
    set_sel(3'h0);
    check("sel", sel_q, SRT_SEL_MAX);
    pulse(6'h02);
    check("running", running_q, 1);
    do_reset();
    check("locked", locked_q, 0);
    check("cause", cause_q, 0);
    pulse(6'h02);
    check("running", running_q, 0);
    // Locking a stopped timer starts it locked
    pulse(6'h08);
    check("running", running_q, 1);
    check("locked", locked_q, 1);
    $display("test_lock done");
  endtask

  task automatic final_report();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Watchdog: the tests need about 600 cycles, 4000 are allowed
  initial begin
    #20000;
    failures++;
    final_report();
  end

  initial begin
    rst        = 1'b1;
    lfo_in     = 1'b0;
    rq         = 6'h00;
    sel_wr_val = 3'h0;
    failures   = 0;
    num_checks = 0;
    test_reset();
    test_overflow();
    test_restart();
    test_disable();
    test_lock();
    check("oe_bad", oe_bad, 0);
    final_report();
  end
endmodule

`default_nettype wire
